// ==== pwi_pkg.sv ====
// Constants and types for the pull-up, watchdog and interrupt enable bank
package pwi_pkg;

  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam int NUM_SRC = 5;

  // Register offsets
  localparam logic [2:0] PULLUP_OFS = 3'h0;
  localparam logic [2:0] WDT_CTL_OFS = 3'h1;
  localparam logic [2:0] IRQ_EN_OFS = 3'h2;
  localparam logic [2:0] IRQ_STAT_OFS = 3'h3;
  localparam logic [2:0] IRQ_CLR_OFS = 3'h4;
  localparam logic [2:0] PORT_DIR_OFS = 3'h5;
  localparam logic [2:0] PORT_DATA_OFS = 3'h6;

  // Implemented bits of the pull-up, watchdog control and interrupt registers
  localparam logic [7:0] PULLUP_MASK = 8'hF7;
  localparam logic [7:0] WDT_CTL_MASK = 8'hFC;
  localparam logic [7:0] IRQ_MASK = 8'h1F;

  // Reset values
  localparam logic [7:0] PULLUP_RST = 8'h00;
  localparam logic [7:0] WDT_CTL_RST = 8'h00;
  localparam logic [7:0] IRQ_EN_RST = 8'h00;
  localparam logic [7:0] PORT_DIR_RST = 8'hFF;
  localparam logic [7:0] PORT_DATA_RST = 8'h00;

  // Watchdog control fields
  localparam int WDT_EN_BIT = 7;
  localparam int EXT_SEL_BIT = 6;
  localparam int PSC_EN_BIT = 5;
  localparam int PSC_SEL_LSB = 2;
  localparam int PSC_SEL_W = 3;

  // Interrupt source positions
  localparam int IRQ_TMR_BIT = 0;
  localparam int IRQ_CHG_BIT = 1;
  localparam int IRQ_EXT_BIT = 2;
  localparam int IRQ_CMP_BIT = 3;
  localparam int IRQ_PWM_BIT = 4;

  // Port pin carrying the active-low external interrupt
  localparam int EXT_PIN = 0;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } pwi_bus_req_t;

  typedef struct packed {
    logic [DATA_W-1:0] out;
    logic [DATA_W-1:0] oe;
    logic [DATA_W-1:0] pullupEn;
  } pwi_pad_t;

endpackage

// ==== pwi_regs.sv ====
// Pull-up, watchdog control and interrupt enable register bank
//
// Summary of operation
// - Pull-up bit 0 enables the pin pull-up, 1 disables; bits 7-4, 2-0.
// - Pull-up register bit 3 is unused and always reads zero.
// - Pull-up register is readable and writable; reads return stored bits.
// - Watchdog control bit 7 enables the watchdog; it reads back.
// - Bit 6 makes port pin 0 the external interrupt; software sets it input.
// - Select bit 0 blocks the external path; port reads still show pin.
// - Bit 5 enables the watchdog prescaler; when 0 the rate is 1:1.
// - Prescaler select bits 4-2 divide by two to the field plus one.
// - Watchdog control bits 1 and 0 always read zero.
// - Interrupt enable bits 7 to 5 always read zero.
// - Interrupt enable bit 4 gates the PWM interrupt.
// - Interrupt enable bit 3 gates the comparator change interrupt.
// - Interrupt enable bit 2 gates the external interrupt.
// - Interrupt enable bit 1 gates the input change interrupt.
// - Interrupt enable bit 0 gates the timer overflow interrupt.
// - Direction bit 1 puts the pin in high impedance; 0 drives it.
//
// Design decisions made here: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps

module pwi_regs (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire pwi_pkg::pwi_bus_req_t busReq,
  output logic [7:0] busRdata,
  input wire logic [7:0] portBIn,
  output pwi_pkg::pwi_pad_t pad,
  input wire logic pwmEvent,
  input wire logic cmpEvent,
  input wire logic inChgEvent,
  input wire logic tmrEvent,
  input wire logic wdtRawTick,
  output logic wdtEnable,
  output logic wdtTick,
  output logic irq
);

  // ==========================================================
  // Helpers
  // ==========================================================
  function automatic logic hit(input pwi_pkg::pwi_bus_req_t r,
                               input logic [2:0] ofs);
    hit = r.addr == ofs;
  endfunction

  function automatic logic [7:0] pscMask(input logic [2:0] sel);
    pscMask = ~(8'hFF << ({1'b0, sel} + 4'h1));
  endfunction

  logic [7:0] pullup_q;
  logic [7:0] wdtCtl_q;
  logic [7:0] irqEn_q;
  logic [4:0] irqStat_q;
  logic [7:0] portDir_q;
  logic [7:0] portData_q;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic [7:0] syncA_q;
  logic [7:0] syncB_q;
  logic [7:0] syncC_q;
  logic [7:0] pinLvl_q;
  logic [7:0] psc_q;
  logic [4:0] events;
  logic extFall;
  logic [2:0] pscSel;

  // ==========================================================
  // Software registers
  // ==========================================================
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      pullup_q <= pwi_pkg::PULLUP_RST;
    else if (busReq.wr && hit(busReq, pwi_pkg::PULLUP_OFS))
      pullup_q <= busReq.wdata & pwi_pkg::PULLUP_MASK;
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      wdtCtl_q <= pwi_pkg::WDT_CTL_RST;
    else if (busReq.wr && hit(busReq, pwi_pkg::WDT_CTL_OFS))
      wdtCtl_q <= busReq.wdata & pwi_pkg::WDT_CTL_MASK;
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      irqEn_q <= pwi_pkg::IRQ_EN_RST;
    else if (busReq.wr && hit(busReq, pwi_pkg::IRQ_EN_OFS))
      irqEn_q <= busReq.wdata & pwi_pkg::IRQ_MASK;
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      portDir_q <= pwi_pkg::PORT_DIR_RST;
    else if (busReq.wr && hit(busReq, pwi_pkg::PORT_DIR_OFS))
      portDir_q <= busReq.wdata;
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      portData_q <= pwi_pkg::PORT_DATA_RST;
    else if (busReq.wr && hit(busReq, pwi_pkg::PORT_DATA_OFS))
      portData_q <= busReq.wdata;
  end

  // ==========================================================
  // Read path: data stands one cycle after the strobe only
  // ==========================================================
  always_comb
  begin
    rdata_d = 8'h00;
    if (busReq.rd)
    begin
      case (busReq.addr)
        pwi_pkg::PULLUP_OFS: rdata_d = pullup_q;
        pwi_pkg::WDT_CTL_OFS: rdata_d = wdtCtl_q;
        pwi_pkg::IRQ_EN_OFS: rdata_d = irqEn_q;
        pwi_pkg::IRQ_STAT_OFS: rdata_d = {3'h0, irqStat_q};
        pwi_pkg::PORT_DIR_OFS: rdata_d = portDir_q;
        pwi_pkg::PORT_DATA_OFS: rdata_d = pinLvl_q;
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      rdata_q <= 8'h00;
    else
      rdata_q <= rdata_d;
  end

  assign busRdata = rdata_q;

  // ==========================================================
  // Pads
  // ==========================================================
  assign pad = '{
    out: portData_q,
    oe: ~portDir_q,
    pullupEn: ~pullup_q & pwi_pkg::PULLUP_MASK
  };

  // ==========================================================
  // Pin synchroniser; a level counts once stages two and three agree
  // ==========================================================
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      syncA_q <= 8'hFF;
      syncB_q <= 8'hFF;
      syncC_q <= 8'hFF;
    end
    else
    begin
      syncA_q <= portBIn;
      syncB_q <= syncA_q;
      syncC_q <= syncB_q;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      pinLvl_q <= 8'hFF;
    else
      pinLvl_q <= (syncB_q & syncC_q) | (pinLvl_q & (syncB_q ^ syncC_q));
  end

  // Active-low input: falling edge of the filtered level, only when selected
  assign extFall = wdtCtl_q[pwi_pkg::EXT_SEL_BIT]
    && pinLvl_q[pwi_pkg::EXT_PIN]
    && !syncB_q[pwi_pkg::EXT_PIN] && !syncC_q[pwi_pkg::EXT_PIN];

  // ==========================================================
  // Interrupt status, enable gating and output
  // ==========================================================
  always_comb
  begin
    events = 5'h00;
    events[pwi_pkg::IRQ_TMR_BIT] = tmrEvent;
    events[pwi_pkg::IRQ_CHG_BIT] = inChgEvent;
    events[pwi_pkg::IRQ_EXT_BIT] = extFall;
    events[pwi_pkg::IRQ_CMP_BIT] = cmpEvent;
    events[pwi_pkg::IRQ_PWM_BIT] = pwmEvent;
  end

  // Set wins over a clear in the same cycle; enables never touch flags
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      irqStat_q <= 5'h00;
    else if (busReq.wr && hit(busReq, pwi_pkg::IRQ_CLR_OFS))
      irqStat_q <= (irqStat_q & ~busReq.wdata[4:0]) | events;
    else
      irqStat_q <= irqStat_q | events;
  end

  assign irq = |(irqStat_q & irqEn_q[4:0]);

  // ==========================================================
  // Watchdog prescaler
  // ==========================================================
  assign pscSel = wdtCtl_q[pwi_pkg::PSC_SEL_LSB +: pwi_pkg::PSC_SEL_W];
  assign wdtEnable = wdtCtl_q[pwi_pkg::WDT_EN_BIT];

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      psc_q <= 8'h00;
    else if (busReq.wr && hit(busReq, pwi_pkg::WDT_CTL_OFS))
      psc_q <= 8'h00;
    else if (wdtRawTick && wdtEnable)
      psc_q <= psc_q + 8'h01;
  end

  assign wdtTick = wdtRawTick && wdtEnable
    && (!wdtCtl_q[pwi_pkg::PSC_EN_BIT]
        || ((psc_q & pscMask(pscSel)) == pscMask(pscSel)));

  // ==========================================================
  // Checks
  // ==========================================================
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);

  logic [8:0] gap_q;
  logic gapValid_q;
  logic wdtWr;

  assign wdtWr = busReq.wr && hit(busReq, pwi_pkg::WDT_CTL_OFS);

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      gap_q <= 9'h000;
      gapValid_q <= 1'b0;
    end
    else if (wdtWr || !wdtEnable)
    begin
      gap_q <= 9'h000;
      gapValid_q <= 1'b0;
    end
    else if (wdtTick)
    begin
      gap_q <= 9'h000;
      gapValid_q <= 1'b1;
    end
    else if (wdtRawTick)
      gap_q <= gap_q + 9'h001;
  end

  a_pullup_pad_polarity: assert property (
    busReq.wr && busReq.addr == pwi_pkg::PULLUP_OFS
    |=> pad.pullupEn == (~$past(busReq.wdata) & pwi_pkg::PULLUP_MASK))
    else $error("pull-up pad enable does not follow written bits");

  a_pullup_bit3_zero: assert property (
    busReq.rd && busReq.addr == pwi_pkg::PULLUP_OFS |=> busRdata[3] == 1'b0)
    else $error("pull-up bit 3 read back nonzero");

  a_pullup_readback: assert property (
    busReq.wr && busReq.addr == pwi_pkg::PULLUP_OFS
    ##1 busReq.rd && busReq.addr == pwi_pkg::PULLUP_OFS
    |=> busRdata == ($past(busReq.wdata, 2) & pwi_pkg::PULLUP_MASK))
    else $error("pull-up register read differs from written value");

  a_wdt_enable_out: assert property (
    wdtWr |=> wdtEnable == $past(busReq.wdata[pwi_pkg::WDT_EN_BIT]))
    else $error("watchdog enable does not follow control write");

  a_ext_path_blocked: assert property (
    !wdtCtl_q[pwi_pkg::EXT_SEL_BIT] && !irqStat_q[pwi_pkg::IRQ_EXT_BIT]
    |=> !irqStat_q[pwi_pkg::IRQ_EXT_BIT])
    else $error("external flag set while pin select is off");

  a_prescale_bypass: assert property (
    wdtEnable && !wdtCtl_q[pwi_pkg::PSC_EN_BIT] && wdtRawTick |-> wdtTick)
    else $error("watchdog tick missing with prescaler off");

  a_prescale_ratio: assert property (
    wdtTick && gapValid_q && wdtCtl_q[pwi_pkg::PSC_EN_BIT]
    |-> gap_q + 9'h001 == (9'h001 << ({1'b0, pscSel} + 4'h1)))
    else $error("watchdog prescale ratio wrong");

  a_wdt_low_zero: assert property (
    busReq.rd && busReq.addr == pwi_pkg::WDT_CTL_OFS
    |=> busRdata[1:0] == 2'b00)
    else $error("watchdog control bits 1..0 read nonzero");

  a_irq_high_zero: assert property (
    busReq.rd && busReq.addr == pwi_pkg::IRQ_EN_OFS
    |=> busRdata[7:5] == 3'b000)
    else $error("interrupt enable bits 7..5 read nonzero");

  a_irq_gated: assert property (
    busReq.wr && busReq.addr == pwi_pkg::IRQ_EN_OFS
    && |(busReq.wdata[4:0] & irqStat_q) |=> irq)
    else $error("interrupt output not raised by enabled flag");

  a_irq_masked_off: assert property (
    irqEn_q[4:0] == 5'h00 |-> !irq)
    else $error("interrupt raised with all sources disabled");

  a_disable_keeps_flag: assert property (
    busReq.wr && busReq.addr == pwi_pkg::IRQ_EN_OFS |=> irqStat_q[4:0]
    == ($past(irqStat_q[4:0]) | $past(events)))
    else $error("enable write altered pending flags");

  a_dir_hiz: assert property (
    busReq.wr && busReq.addr == pwi_pkg::PORT_DIR_OFS
    |=> pad.oe == ~$past(busReq.wdata))
    else $error("pad output enable does not follow direction");

  a_pad_out_follows: assert property (
    busReq.wr && busReq.addr == pwi_pkg::PORT_DATA_OFS
    |=> pad.out == $past(busReq.wdata))
    else $error("pad output data does not follow port data write");

  a_rdata_idle: assert property (
    !busReq.rd |=> busRdata == 8'h00)
    else $error("read data present without a read strobe");

  a_status_sticky: assert property (
    !(busReq.wr && busReq.addr == pwi_pkg::IRQ_CLR_OFS)
    |=> (irqStat_q & $past(irqStat_q)) == $past(irqStat_q))
    else $error("pending flag dropped without a clear write");

  a_set_wins_clear: assert property (
    busReq.wr && busReq.addr == pwi_pkg::IRQ_CLR_OFS
    |=> (irqStat_q & $past(events)) == $past(events))
    else $error("event lost to a clear in the same cycle");

  c_ext_irq: cover property (
    wdtCtl_q[pwi_pkg::EXT_SEL_BIT] && extFall
    ##1 irqStat_q[pwi_pkg::IRQ_EXT_BIT]);
  c_prescale_max: cover property (
    wdtTick && gapValid_q && pscSel == 3'h7);
  c_set_clear_same: cover property (
    busReq.wr && busReq.addr == pwi_pkg::IRQ_CLR_OFS && |events);
  c_irq_raise: cover property ($rose(irq));
  c_write_then_read: cover property (busReq.wr ##1 busReq.rd);

endmodule

// ==== pwi_regs_tb_top.sv ====
// Self-checking testbench for the pull-up, watchdog and interrupt bank
`timescale 1ns/1ps

module pwi_regs_tb_top;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  pwi_pkg::pwi_bus_req_t busReq = '0;
  logic [7:0] busRdata;
  logic [7:0] portBIn = 8'hFF;
  pwi_pkg::pwi_pad_t pad;
  logic [3:0] ev = 4'h0;
  logic wdtRawTick = 1'b0;
  logic wdtEnable;
  logic wdtTick;
  logic irq;
  int miscompares = 0;
  int nChecks = 0;
  int cycles = 0;

  pwi_regs i_dut (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .busReq(busReq),
    .busRdata(busRdata),
    .portBIn(portBIn),
    .pad(pad),
    .pwmEvent(ev[3]),
    .cmpEvent(ev[2]),
    .inChgEvent(ev[1]),
    .tmrEvent(ev[0]),
    .wdtRawTick(wdtRawTick),
    .wdtEnable(wdtEnable),
    .wdtTick(wdtTick),
    .irq(irq)
  );

  always #4 ref_clk = ~ref_clk;

  // ==========================================================
  // Shared tasks
  task automatic check(input string name, input logic [15:0] seen,
                       input logic [15:0] exp);
    nChecks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic testDone();
    $display("checks %0d miscompares %0d", nChecks, miscompares);
    if (miscompares == 0 && nChecks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic regWrite(input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    busReq <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge ref_clk);
    busReq <= '0;
    #1;
  endtask

  task automatic regCheck(input string name, input logic [2:0] a,
                          input logic [7:0] exp);
    @(posedge ref_clk);
    busReq <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge ref_clk);
    busReq <= '0;
    #1;
    check(name, {8'h00, busRdata}, {8'h00, exp});
  endtask

  // ==========================================================
  // Scenarios
  task automatic testRegs();
    check("pullupEn", pad.pullupEn, 16'h00F7);
    regCheck("pullup", pwi_pkg::PULLUP_OFS, 8'h00);
    regWrite(pwi_pkg::PULLUP_OFS, 8'hFF);
    check("pullupEn", pad.pullupEn, 16'h0000);
    regCheck("pullup", pwi_pkg::PULLUP_OFS, 8'hF7);
    regWrite(pwi_pkg::PULLUP_OFS, 8'h5A);
    check("pullupEn", pad.pullupEn, 16'h00A5);
    regCheck("pullup", pwi_pkg::PULLUP_OFS, 8'h52);
    regWrite(pwi_pkg::WDT_CTL_OFS, 8'hFF);
    check("wdtEnable", wdtEnable, 16'h0001);
    regCheck("wdtctl", pwi_pkg::WDT_CTL_OFS, 8'hFC);
    regWrite(pwi_pkg::WDT_CTL_OFS, 8'h00);
    check("wdtEnable", wdtEnable, 16'h0000);
    regWrite(pwi_pkg::IRQ_EN_OFS, 8'hFF);
    regCheck("irqen", pwi_pkg::IRQ_EN_OFS, 8'h1F);
    regWrite(pwi_pkg::IRQ_EN_OFS, 8'h00);
    regWrite(pwi_pkg::IRQ_STAT_OFS, 8'hFF);
    regCheck("status", pwi_pkg::IRQ_STAT_OFS, 8'h00);
    regCheck("clear", pwi_pkg::IRQ_CLR_OFS, 8'h00);
    regCheck("unmapped", 3'h7, 8'h00);
  endtask

  task automatic testWdt(input logic [7:0] ctl, input int exp);
    int cnt;
    cnt = 0;
    regWrite(pwi_pkg::WDT_CTL_OFS, ctl);
    for (int i = 0; i < 256; i++)
    begin
      @(posedge ref_clk);
      wdtRawTick <= 1'b1;
      #1;
      if (wdtTick === 1'b1)
        cnt++;
    end
    @(posedge ref_clk);
    wdtRawTick <= 1'b0;
    check("wdtTicks", cnt[15:0], exp[15:0]);
  endtask

  task automatic testIrqSources();
    int pos [4];
    logic [7:0] b;
    pos = '{pwi_pkg::IRQ_TMR_BIT, pwi_pkg::IRQ_CHG_BIT,
            pwi_pkg::IRQ_CMP_BIT, pwi_pkg::IRQ_PWM_BIT};
    for (int i = 0; i < 4; i++)
    begin
      b = 8'h01 << pos[i];
      regWrite(pwi_pkg::IRQ_EN_OFS, ~b & pwi_pkg::IRQ_MASK);
      @(posedge ref_clk);
      ev[i] <= 1'b1;
      @(posedge ref_clk);
      ev[i] <= 1'b0;
      #1;
      check("irqMasked", irq, 16'h0000);
      regCheck("status", pwi_pkg::IRQ_STAT_OFS, b);
      regWrite(pwi_pkg::IRQ_EN_OFS, b);
      check("irqOn", irq, 16'h0001);
      regWrite(pwi_pkg::IRQ_EN_OFS, 8'h00);
      check("irqOff", irq, 16'h0000);
      regCheck("statusKept", pwi_pkg::IRQ_STAT_OFS, b);
      regWrite(pwi_pkg::IRQ_CLR_OFS, b);
      regCheck("statusClr", pwi_pkg::IRQ_STAT_OFS, 8'h00);
    end
  endtask

  task automatic pinFall(input logic sel);
    regWrite(pwi_pkg::WDT_CTL_OFS, {1'b0, sel, 6'h00});
    @(posedge ref_clk);
    portBIn <= 8'hFE;
    repeat (8) @(posedge ref_clk);
    #1;
    check("extIrq", irq, {15'h0000, sel});
    regCheck("extStatus", pwi_pkg::IRQ_STAT_OFS, {5'h00, sel, 2'h0});
    regCheck("portRead", pwi_pkg::PORT_DATA_OFS, 8'hFE);
    regWrite(pwi_pkg::IRQ_CLR_OFS, 8'h04);
    @(posedge ref_clk);
    portBIn <= 8'hFF;
    repeat (8) @(posedge ref_clk);
  endtask

  task automatic testExtPin();
    regWrite(pwi_pkg::PORT_DIR_OFS, 8'h01);
    check("padOe", pad.oe, 16'h00FE);
    regWrite(pwi_pkg::PORT_DATA_OFS, 8'hA5);
    check("padOut", pad.out, 16'h00A5);
    regWrite(pwi_pkg::IRQ_EN_OFS, 8'h04);
    pinFall(1'b0);
    pinFall(1'b1);
    regWrite(pwi_pkg::IRQ_EN_OFS, 8'h00);
  endtask

  // Write and read with no idle cycle between, then idle read data
  task automatic testBackToBack();
    @(posedge ref_clk);
    busReq <= '{wr: 1'b1, rd: 1'b0, addr: pwi_pkg::PULLUP_OFS, wdata: 8'h3C};
    @(posedge ref_clk);
    busReq <= '{wr: 1'b0, rd: 1'b1, addr: pwi_pkg::PULLUP_OFS, wdata: 8'h00};
    @(posedge ref_clk);
    busReq <= '0;
    #1;
    check("backToBack", busRdata, 16'h0034);
    @(posedge ref_clk);
    #1;
    check("rdataIdle", busRdata, 16'h0000);
  endtask

  // ==========================================================
  // Main sequence and timeout
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      testDone();
    end
  end

  initial
  begin
    repeat (8) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    #1;
    check("resetOe", pad.oe, 16'h0000);
    check("resetIrq", irq, 16'h0000);
    check("resetWdt", wdtEnable, 16'h0000);
    testRegs();
    testBackToBack();
    testWdt(8'h00, 0);
    testWdt(8'h80, 256);
    for (int s = 0; s < 8; s++)
      testWdt(8'hA0 | (s << 2), 256 >> (s + 1));
    regWrite(pwi_pkg::WDT_CTL_OFS, 8'h00);
    testIrqSources();
    testExtPin();
    testDone();
  end
endmodule
